// file: inc/eai_pkg.sv
// constants and types for the alarm and error interrupt block
package eai_pkg;
  // ----------------------------------------
  // register indices and byte addresses
  // ----------------------------------------
  localparam logic [15:0] IDX_BLK = 16'h0B01;
  localparam logic [15:0] IDX_STS = 16'h0B02;
  localparam logic [15:0] IDX_EN  = 16'h0B03;
  localparam logic [15:0] IDX_FCR = 16'h010B;
  localparam logic [15:0] ADR_BLK = {IDX_BLK[13:0], 2'h0};
  localparam logic [15:0] ADR_STS = {IDX_STS[13:0], 2'h0};
  localparam logic [15:0] ADR_EN  = {IDX_EN[13:0], 2'h0};
  localparam logic [15:0] ADR_FCR = {IDX_FCR[13:0], 2'h0};
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_YEL   = 0;
  localparam int B_AIS   = 1;
  localparam int B_OOF   = 2;
  localparam int B_LCV   = 3;
  localparam int B_MYEL  = 5;
  localparam int B_LIVE  = 7;
  localparam int B_BLKEN = 1;
  localparam int ALIGNMENT_LOSS_COUNT_W  = 3;
  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [7:0] STS_RST  = 8'h00;
  localparam logic [7:0] EN_RST   = 8'h00;
  localparam logic [7:0] BLK_RST  = 8'h00;
  localparam logic [7:0] FCR_RST  = 8'h03;
  localparam logic [7:0] EN_WMASK = 8'h3F;
  localparam logic [7:0] SRC_MASK = 8'h2F;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [1:0] ZSAT     = 2'h3;
  // ----------------------------------------
  // event vector, laid out as the status bits
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] unused;
    logic       myel;
    logic       rsv;
    logic       coding_violation;
    logic       frame_loss_defect;
    logic       all_ones_alarm;
    logic       yel;
  } eai_evt_t;
endpackage

// file: verilog/eai_top.sv
// alarm and error event status, enables and interrupt with axi4-lite access
`timescale 1ns/1ps
module eai_top (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_N_I,
  input  wire logic [15:0] AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [15:0] ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        CODE_VIOL_I,
  input  wire logic        FAS_STB_I,
  input  wire logic        FAS_ERR_I,
  input  wire logic        ZERO_BIT_I,
  input  wire logic        FRM_STB_I,
  input  wire logic        NFAS_STB_I,
  input  wire logic        A_BIT_I,
  input  wire logic        MF_YEL_I,
  output logic             IRQ_O
);
  // ----------------------------------------
  // address helpers
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a[15:2] == r[15:2]);
  endfunction

  function automatic logic mapped(input logic [15:0] a);
    mapped = hit(a, eai_pkg::ADR_BLK) | hit(a, eai_pkg::ADR_STS) |
             hit(a, eai_pkg::ADR_EN) | hit(a, eai_pkg::ADR_FCR);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]  sts_r, sts_nxt, en_r, en_nxt, blk_r, blk_nxt, fcr_r, fcr_nxt;
  logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, ardy_r, ardy_nxt;
  logic        awf_r, awf_nxt, wf_r, wf_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [15:0] awa_r, awa_nxt;
  logic [7:0]  wd_r, wd_nxt;
  logic        ws_r, ws_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        irq_r, irq_nxt;
  logic        oof_r, oof_nxt, ais_r, ais_nxt, yel_r, yel_nxt;
  logic        ap_r, ap_nxt, myel_r, myel_nxt;
  logic [2:0]  ecnt_r, ecnt_nxt;
  logic [1:0]  zc_r, zc_nxt, zp_r, zp_nxt;
  logic [1:0]  zcur;
  logic [2:0]  crit;
  logic        do_wr, ar_take, rd_clr;
  logic [7:0]  wclr;
  eai_pkg::eai_evt_t evt;

  // ----------------------------------------
  // framer condition tracking
  // ----------------------------------------
  // zeros of the frame that ends this cycle, saturating at three
  assign zcur = (ZERO_BIT_I && zc_r != eai_pkg::ZSAT) ? zc_r + 2'h1 : zc_r;
  // a zero criterion is treated as one; with the >= compare both declare loss on the first error
  assign crit = (fcr_r[eai_pkg::ALIGNMENT_LOSS_COUNT_W-1:0] == 3'h0) ? 3'h1 : fcr_r[eai_pkg::ALIGNMENT_LOSS_COUNT_W-1:0];

  always_comb begin
    oof_nxt  = oof_r;
    ecnt_nxt = ecnt_r;
    ais_nxt  = ais_r;
    zc_nxt   = zcur;
    zp_nxt   = zp_r;
    yel_nxt  = yel_r;
    ap_nxt   = ap_r;
    myel_nxt = MF_YEL_I;
    if (FAS_STB_I) begin
      if (FAS_ERR_I) begin
        ecnt_nxt = (ecnt_r == 3'h7) ? ecnt_r : ecnt_r + 3'h1;
        if (ecnt_nxt >= crit) oof_nxt = 1'b1;
      end else begin
        ecnt_nxt = 3'h0;
        oof_nxt  = 1'b0;
      end
    end
    // all-ones alarm over two frame windows
    if (FRM_STB_I) begin
      if (zp_r == 2'h0 && zcur == 2'h0) ais_nxt = 1'b1;
      else if ({1'b0, zp_r} + {1'b0, zcur} > 3'h2) ais_nxt = 1'b0;
      zp_nxt = zcur;
      zc_nxt = 2'h0;
    end
    // two ones declare the live remote alarm
    if (NFAS_STB_I) begin
      if (A_BIT_I && ap_r) yel_nxt = 1'b1;
      else if (!A_BIT_I && !ap_r) yel_nxt = 1'b0;
      ap_nxt = A_BIT_I;
    end
    evt        = '0;
    evt.coding_violation    = CODE_VIOL_I;
    evt.frame_loss_defect    = oof_nxt ^ oof_r;
    evt.all_ones_alarm    = ais_nxt ^ ais_r;
    evt.yel    = yel_nxt ^ yel_r;
    evt.myel   = myel_nxt ^ myel_r;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      oof_r  <= 1'b0;
      ecnt_r <= 3'h0;
      ais_r  <= 1'b0;
      zc_r   <= 2'h0;
      zp_r   <= eai_pkg::ZSAT;
      yel_r  <= 1'b0;
      ap_r   <= 1'b0;
      myel_r <= 1'b0;
    end else begin
      oof_r  <= oof_nxt;
      ecnt_r <= ecnt_nxt;
      ais_r  <= ais_nxt;
      zc_r   <= zc_nxt;
      zp_r   <= zp_nxt;
      yel_r  <= yel_nxt;
      ap_r   <= ap_nxt;
      myel_r <= myel_nxt;
    end
  end

  // ----------------------------------------
  // axi4-lite slave and registers
  // ----------------------------------------
  // one write commits once both halves are held and no response is pending
  assign do_wr   = awf_r & wf_r & ~bv_r;
  assign ar_take = ARVALID_I & ardy_r;
  // a status read clears what it returned
  assign rd_clr  = ar_take & hit(ARADDR_I, eai_pkg::ADR_STS);
  assign wclr    = (do_wr && ws_r && hit(awa_r, eai_pkg::ADR_STS)) ? wd_r : 8'h00;

  always_comb begin
    awf_nxt = awf_r;
    wf_nxt  = wf_r;
    awa_nxt = awa_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    bv_nxt  = bv_r;
    br_nxt  = br_r;
    rv_nxt  = rv_r;
    rr_nxt  = rr_r;
    rd_nxt  = rd_r;
    en_nxt  = en_r;
    blk_nxt = blk_r;
    fcr_nxt = fcr_r;
    if (AWVALID_I && awrdy_r) begin
      awf_nxt = 1'b1;
      awa_nxt = AWADDR_I;
    end
    if (WVALID_I && wrdy_r) begin
      wf_nxt = 1'b1;
      wd_nxt = WDATA_I[7:0];
      ws_nxt = WSTRB_I[0];
    end
    if (BREADY_I && bv_r) bv_nxt = 1'b0;
    if (do_wr) begin
      awf_nxt = 1'b0;
      wf_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = mapped(awa_r) ? eai_pkg::RESP_OK : eai_pkg::RESP_ERR;
      if (ws_r) begin
        // enable bits 5..0 are writable, bit 7 shows live state
        if (hit(awa_r, eai_pkg::ADR_EN)) en_nxt = wd_r & eai_pkg::EN_WMASK;
        if (hit(awa_r, eai_pkg::ADR_BLK)) blk_nxt = wd_r;
        if (hit(awa_r, eai_pkg::ADR_FCR)) fcr_nxt = wd_r;
      end
    end
    if (RREADY_I && rv_r) rv_nxt = 1'b0;
    if (ar_take) begin
      rv_nxt = 1'b1;
      rr_nxt = mapped(ARADDR_I) ? eai_pkg::RESP_OK : eai_pkg::RESP_ERR;
      rd_nxt = 32'h0000_0000;
      if (hit(ARADDR_I, eai_pkg::ADR_STS)) rd_nxt[7:0] = sts_r;
      if (hit(ARADDR_I, eai_pkg::ADR_EN)) rd_nxt[7:0] = {yel_r, en_r[6:0]};
      if (hit(ARADDR_I, eai_pkg::ADR_BLK)) rd_nxt[7:0] = blk_r;
      if (hit(ARADDR_I, eai_pkg::ADR_FCR)) rd_nxt[7:0] = fcr_r;
    end
    awrdy_nxt = ~awf_nxt;
    wrdy_nxt  = ~wf_nxt;
    ardy_nxt  = ~rv_nxt;
    // new events win over the clearing read or write
    sts_nxt = (sts_r & ~(rd_clr ? 8'hFF : 8'h00) & ~wclr) | (evt & eai_pkg::SRC_MASK);
    // source enables gate each bit, gates the block
    irq_nxt = blk_nxt[eai_pkg::B_BLKEN] & (|(sts_nxt & en_nxt & eai_pkg::SRC_MASK));
  end

  // enables, status and interrupt reset to zero
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      awrdy_r <= 1'b0;
      wrdy_r  <= 1'b0;
      ardy_r  <= 1'b0;
      awf_r   <= 1'b0;
      wf_r    <= 1'b0;
      awa_r   <= 16'h0000;
      wd_r    <= 8'h00;
      ws_r    <= 1'b0;
      bv_r    <= 1'b0;
      br_r    <= 2'h0;
      rv_r    <= 1'b0;
      rr_r    <= 2'h0;
      rd_r    <= 32'h0000_0000;
      sts_r   <= eai_pkg::STS_RST;
      en_r    <= eai_pkg::EN_RST;
      blk_r   <= eai_pkg::BLK_RST;
      fcr_r   <= eai_pkg::FCR_RST;
      irq_r   <= 1'b0;
    end else begin
      awrdy_r <= awrdy_nxt;
      wrdy_r  <= wrdy_nxt;
      ardy_r  <= ardy_nxt;
      awf_r   <= awf_nxt;
      wf_r    <= wf_nxt;
      awa_r   <= awa_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      bv_r    <= bv_nxt;
      br_r    <= br_nxt;
      rv_r    <= rv_nxt;
      rr_r    <= rr_nxt;
      rd_r    <= rd_nxt;
      sts_r   <= sts_nxt;
      en_r    <= en_nxt;
      blk_r   <= blk_nxt;
      fcr_r   <= fcr_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // outputs straight from flops
  assign AWREADY_O = awrdy_r;
  assign WREADY_O  = wrdy_r;
  assign BVALID_O  = bv_r;
  assign BRESP_O   = br_r;
  assign ARREADY_O = ardy_r;
  assign RVALID_O  = rv_r;
  assign RRESP_O   = rr_r;
  assign RDATA_O   = rd_r;
  assign IRQ_O     = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);

  AST_LCV_SET: assert property (CODE_VIOL_I |=> sts_r[eai_pkg::B_LCV])
    else $error("coding violation not latched");
  AST_OOF_CHG: assert property ((oof_nxt != oof_r) |=> sts_r[eai_pkg::B_OOF])
    else $error("frame loss change not latched");
  AST_OOF_DECL: assert property (FAS_STB_I && FAS_ERR_I && ecnt_r + 3'h1 >= crit && ecnt_r != 3'h7
    |=> oof_r)
    else $error("frame loss not declared at count");
  AST_AIS_CHG: assert property ((ais_nxt != ais_r) |=> sts_r[eai_pkg::B_AIS])
    else $error("all-ones change not latched");
  AST_YEL_CHG: assert property ($changed(yel_r) |-> sts_r[eai_pkg::B_YEL])
    else $error("remote alarm change not latched");
  AST_RD_CLR: assert property (rd_clr && evt == '0 && wclr == 8'h00 |=> sts_r == 8'h00 &&
    RDATA_O[7:0] == $past(sts_r))
    else $error("status read did not return and clear");
  AST_YEL_ON: assert property (NFAS_STB_I && A_BIT_I ##1 NFAS_STB_I && A_BIT_I |=> yel_r)
    else $error("remote alarm not declared");
  AST_YEL_OFF: assert property (NFAS_STB_I && !A_BIT_I ##1 NFAS_STB_I && !A_BIT_I |=> !yel_r)
    else $error("remote alarm not cleared");
  AST_AIS_DECL: assert property (FRM_STB_I && zp_r == 2'h0 && zcur == 2'h0 |=> ais_r)
    else $error("all-ones alarm not declared");
  // irq and block enable load on the same edge, so a cleared block enable means a quiet pin
  AST_BLK_GATE: assert property (!blk_r[eai_pkg::B_BLKEN] |-> !IRQ_O)
    else $error("interrupt without block enable");
  AST_IRQ_ON: assert property (blk_r[eai_pkg::B_BLKEN] && |(sts_r & en_r & eai_pkg::SRC_MASK) |-> IRQ_O)
    else $error("interrupt missing for enabled status");
  AST_EN_GATE: assert property (IRQ_O |-> |(sts_r & en_r & eai_pkg::SRC_MASK))
    else $error("interrupt from disabled source");

  COV_IRQ: cover property (CODE_VIOL_I ##1 sts_r[eai_pkg::B_LCV] ##1 IRQ_O);
  COV_RACE: cover property (rd_clr && evt.coding_violation);
  COV_OOF: cover property ($rose(oof_r) ##[1:50] $fell(oof_r));
  COV_YEL: cover property ($rose(yel_r));
endmodule

// file: dv/eai_top_bench.sv
// self-checking bench for the alarm and error interrupt block
`timescale 1ns/1ps
module eai_top_bench;
  // ----------------------------------------
  // stimulus, observation and model state
  // ----------------------------------------
  logic        CLK_SYS_I, RESET_N_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
  logic        CODE_VIOL_I, FAS_STB_I, FAS_ERR_I, ZERO_BIT_I, FRM_STB_I, NFAS_STB_I, A_BIT_I, MF_YEL_I;
  logic [15:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O, rd_d;
  logic [3:0]  WSTRB_I;
  logic [1:0]  BRESP_O, RRESP_O, resp;
  logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O;
  logic        live, all_ones_alarm, frame_loss_defect;
  logic [7:0]  blk, en;
  int          err_total, checked, crit, kk[5];
  integer      seed;

  eai_top dut (
    .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .CODE_VIOL_I(CODE_VIOL_I),
    .FAS_STB_I(FAS_STB_I), .FAS_ERR_I(FAS_ERR_I), .ZERO_BIT_I(ZERO_BIT_I), .FRM_STB_I(FRM_STB_I),
    .NFAS_STB_I(NFAS_STB_I), .A_BIT_I(A_BIT_I), .MF_YEL_I(MF_YEL_I), .IRQ_O(IRQ_O)
  );

  // 50 MHz clock
  initial begin
    CLK_SYS_I = 1'b0;
    forever #10 CLK_SYS_I = ~CLK_SYS_I;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // interrupt level expected from block enable, source enables and status
  function automatic logic irq_exp(input logic [7:0] b, input logic [7:0] e, input logic [7:0] s);
    return b[1] & (|(s & e & 8'h2F));
  endfunction

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge CLK_SYS_I);
    AWADDR_I  <= a;
    WDATA_I   <= {24'h000000, d};
    AWVALID_I <= 1'b1;
    WVALID_I  <= 1'b1;
    BREADY_I  <= 1'b1;
    do begin
      @(posedge CLK_SYS_I);
      if (AWREADY_O) AWVALID_I <= 1'b0;
      if (WREADY_O) WVALID_I <= 1'b0;
    end while (BVALID_O !== 1'b1);
    r = BRESP_O;
    BREADY_I <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK_SYS_I);
    ARADDR_I  <= a;
    ARVALID_I <= 1'b1;
    RREADY_I  <= 1'b1;
    do begin
      @(posedge CLK_SYS_I);
      if (ARREADY_O) ARVALID_I <= 1'b0;
    end while (RVALID_O !== 1'b1);
    d = RDATA_O;
    r = RRESP_O;
    RREADY_I <= 1'b0;
  endtask

  // one event source per call, strobed as many times as it needs to change its condition
  task automatic fire(input int k);
    @(posedge CLK_SYS_I);
    case (k)
      0: begin
        A_BIT_I    <= ~live;
        NFAS_STB_I <= 1'b1;
        repeat (2) @(posedge CLK_SYS_I);
        NFAS_STB_I <= 1'b0;
        live = ~live;
      end
      1: begin
        ZERO_BIT_I <= all_ones_alarm;
        repeat (3) @(posedge CLK_SYS_I);
        ZERO_BIT_I <= 1'b0;
        FRM_STB_I  <= 1'b1;
        repeat (all_ones_alarm ? 1 : 2) @(posedge CLK_SYS_I);
        FRM_STB_I  <= 1'b0;
        all_ones_alarm = ~all_ones_alarm;
      end
      2: begin
        FAS_ERR_I <= ~frame_loss_defect;
        for (int j = 0; j < crit - 1 && !frame_loss_defect; j++) begin
          FAS_STB_I <= 1'b1;
          @(posedge CLK_SYS_I);
          FAS_STB_I <= 1'b0;
          @(posedge CLK_SYS_I);
        end
        if (!frame_loss_defect) rd(eai_pkg::ADR_STS, rd_d, resp);
        if (!frame_loss_defect) chk(rd_d, 32'h0, "early frame loss");
        FAS_STB_I <= 1'b1;
        @(posedge CLK_SYS_I);
        FAS_STB_I <= 1'b0;
        frame_loss_defect = ~frame_loss_defect;
      end
      3: begin
        CODE_VIOL_I <= 1'b1;
        @(posedge CLK_SYS_I);
        CODE_VIOL_I <= 1'b0;
      end
      default: MF_YEL_I <= ~MF_YEL_I;
    endcase
    repeat (2) @(posedge CLK_SYS_I);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {RESET_N_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 6'h00;
    {CODE_VIOL_I, FAS_STB_I, FAS_ERR_I, ZERO_BIT_I, FRM_STB_I, NFAS_STB_I, A_BIT_I, MF_YEL_I} = 8'h00;
    {AWADDR_I, ARADDR_I, WDATA_I} = 64'h0;
    WSTRB_I = 4'hF;
    {live, all_ones_alarm, frame_loss_defect, err_total, checked} = '0;
    seed = 32'hB20871B1;
    kk = '{0, 1, 2, 3, 5};
    repeat (20) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'b1;
    // reset values, read through the bus
    rd(eai_pkg::ADR_STS, rd_d, resp);
    chk(rd_d, 32'h0, "status reset");
    rd(eai_pkg::ADR_EN, rd_d, resp);
    chk(rd_d, 32'h0, "enable reset");
    rd(eai_pkg::ADR_BLK, rd_d, resp);
    chk(rd_d, 32'h0, "block enable reset");
    rd(eai_pkg::ADR_FCR, rd_d, resp);
    chk(rd_d, 32'h3, "framing control reset");
    chk(IRQ_O, 1'b0, "irq after reset");
    $display("test reset done");
    // unmapped place is refused
    wr(16'h0100, 8'hFF, resp);
    chk(resp, eai_pkg::RESP_ERR, "unmapped write");
    rd(16'h0100, rd_d, resp);
    chk(resp, eai_pkg::RESP_ERR, "unmapped read response");
    chk(rd_d, 32'h0, "unmapped read data");
    crit = 1 + (($random(seed) & 32'hFF) % 7);
    wr(eai_pkg::ADR_FCR, crit[7:0], resp);
    chk(resp, eai_pkg::RESP_OK, "criteria write response");
    // byte lane 0 off must leave the register alone
    WSTRB_I <= 4'hE;
    wr(eai_pkg::ADR_FCR, 8'h00, resp);
    WSTRB_I <= 4'hF;
    chk(resp, eai_pkg::RESP_OK, "strobeless write response");
    rd(eai_pkg::ADR_FCR, rd_d, resp);
    chk(resp, eai_pkg::RESP_OK, "criteria read response");
    chk(rd_d, crit, "criteria readback");
    $display("test access done");
    // every source declared and cleared, enabled, masked and block-gated
    for (int p = 0; p < 4; p++) begin
      blk = (p == 3) ? 8'h00 : 8'h02;
      wr(eai_pkg::ADR_BLK, blk, resp);
      foreach (kk[i]) begin
        en = $random(seed) & 8'h2F;
        if (p == 0) en[kk[i]] = 1'b1;
        if (p == 1) en[kk[i]] = 1'b0;
        wr(eai_pkg::ADR_EN, en | 8'hC0, resp);
        rd(eai_pkg::ADR_EN, rd_d, resp);
        chk(rd_d, {24'h0, live, 1'b0, en[5:0]}, "enable readback");
        fire(kk[i]);
        chk(IRQ_O, irq_exp(blk, en, 8'h1 << kk[i]), "irq level");
        rd(eai_pkg::ADR_EN, rd_d, resp);
        chk(rd_d[7], live, "live remote alarm");
        if (p == 2) wr(eai_pkg::ADR_STS, 8'h1 << kk[i], resp);
        else rd(eai_pkg::ADR_STS, rd_d, resp);
        if (p != 2) chk(rd_d, 32'h1 << kk[i], "event status");
        @(posedge CLK_SYS_I);
        chk(IRQ_O, 1'b0, "irq after clear");
        rd(eai_pkg::ADR_STS, rd_d, resp);
        chk(rd_d, 32'h0, "status cleared");
      end
      $display("test pass %0d done", p);
    end
    end_sim();
  end

  // watchdog: the sequence needs a few hundred cycles
  initial begin
    repeat (40000) @(posedge CLK_SYS_I);
    err_total++;
    end_sim();
  end
endmodule
